// [hdl/cache_cause_consts.svh]
// Function
// - Three-bit divide field: 000 undivided, 001..110 divide by 2..64, 111 reserved.
// - Reset clears the divide field to 000.
// - Leaving halt mode clears the divide field to 000.
// - A divided setting slows pipeline and bus interface by the chosen ratio.
// - Force-data-miss bit 19 makes cacheable loads miss, honoring block refill.
// - Forced data misses still let stores and refills write the data cache.
// - Reset clears the force-data-miss bit.
// - Each force-miss bit is ORed with the emulator force-miss pin.
// - Force-instruction-miss bit makes fetches miss, refilled by four words.
// - Reset clears the force-instruction-miss bit.
// - Data write-inhibit blocks all data cache writes, refills and stores.
// - Instruction write-inhibit blocks all instruction cache writes.
// - Cause holds a five-bit code of the latest exception.
// - Codes: 0 interrupt, 4..12 as listed, 13..31 reserved.
// - Translation exception codes 1 to 3 are never reported.
// - All cause fields except software interrupt bits are read-only.
// - Writing 1 sets a software interrupt, writing 0 clears it.
// - Exception in a delay slot sets the flag, return address points at branch.
// - Coprocessor-unusable exception records the coprocessor number.
// - Pending field shows every pending interrupt regardless of masks.
// - Once lock is written 1, config writes are ignored until reset.
// - Halt bit stalls the pipeline until any interrupt or reset.
// - Data misses refill four words with block refill 1, else one.
`ifndef CACHE_CAUSE_CONSTS_SVH
`define CACHE_CAUSE_CONSTS_SVH
`define CFG_REG_IDX      5'h03
`define CAUSE_REG_IDX    5'h0d
`define CFG_LOCK_BIT     31
`define CFG_BLKREF_BIT   29
`define CFG_DIDX_LSB     27
`define CFG_HALT_BIT     25
`define CFG_IIDX_LSB     23
`define CFG_DIV_LSB      20
`define CFG_FDM_BIT      19
`define CFG_FIM_BIT      18
`define CFG_DWI_BIT      17
`define CFG_IWI_BIT      16
`define CAU_SOFT_LSB     8
`define DIV_RST          3'h0
`define DIV_RESERVED     3'h7
`define IDX_RST          2'h0
`define EXC_CPU          5'h0b
`define EXC_TLB_LAST     5'h03
`define EXC_LAST_LEGAL   5'h0c
`define QUAD_WORDS       3'h4
`define SINGLE_WORDS     3'h1
`define PC_STEP          32'h0000_0004
`endif

// [hdl/cache_cause_pkg.sv]
`default_nettype none
package cache_cause_pkg;
	typedef struct packed {
		logic       lock;
		logic       block_refill;
		logic [1:0] dcache_index;
		logic       halt;
		logic [1:0] icache_index;
		logic [2:0] clock_divide_select;
		logic       force_data_miss;
		logic       force_instr_miss;
		logic       data_cache_write_inhibit;
		logic       instr_cache_write_inhibit;
	} cache_ctl_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  code;
		logic        in_delay;
		logic [1:0]  cop_unit;
		logic [31:0] pc;
	} exc_event_t;
endpackage
`default_nettype wire

// [hdl/cache_config_and_cause_regs.sv]
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cache_cause_consts.svh"
module cache_config_and_cause_regs
	import cache_cause_pkg::*;
#(
	parameter int HW_INTS = 6
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire exc_event_t  exc_in,
	input  wire logic [HW_INTS-1:0] hw_int_pins,
	input  wire logic        emulator_miss_force_pin,
	input  wire logic        dcache_refill_wr,
	input  wire logic        dcache_store_wr,
	input  wire logic        icache_refill_wr,
	output logic             dcache_wr_en,
	output logic             icache_wr_en,
	output logic             force_data_miss,
	output logic             force_instr_miss,
	output logic      [2:0]  data_refill_words,
	output logic      [2:0]  instr_refill_words,
	output logic             pipe_bus_tick,
	output logic             pipeline_stall,
	output cache_ctl_t       cache_ctl,
	output logic      [31:0] exception_return_pc
);

	// Pin inputs: three stages, a change is taken once stages two and three agree.
	localparam int SYN_W = HW_INTS + 1;
	logic [SYN_W-1:0] pin_raw;
	logic [SYN_W-1:0] sync1_q;
	logic [SYN_W-1:0] sync2_q;
	logic [SYN_W-1:0] sync3_q;
	logic [SYN_W-1:0] pin_q;

	assign pin_raw = {emulator_miss_force_pin, hw_int_pins};

	genvar gi;
	generate
		for (gi = 0; gi < SYN_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					sync1_q[gi] <= 1'h0;
					sync2_q[gi] <= 1'h0;
					sync3_q[gi] <= 1'h0;
					pin_q[gi]   <= 1'h0;
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi]) begin
						pin_q[gi] <= sync3_q[gi];
					end
				end
			end
		end
	endgenerate

	wire logic [HW_INTS-1:0] pending_interrupts;
	wire logic               emu_force;
	assign pending_interrupts = pin_q[HW_INTS-1:0];
	assign emu_force          = pin_q[HW_INTS];

	// Register decode.
	wire logic cfg_sel;
	wire logic cause_sel;
	wire logic cfg_wr;
	wire logic cfg_wr_en;
	wire logic cause_wr;
	assign cfg_sel   = (reg_addr == `CFG_REG_IDX);
	assign cause_sel = (reg_addr == `CAUSE_REG_IDX);
	assign cfg_wr    = reg_wr && cfg_sel;
	assign cfg_wr_en = cfg_wr && !cache_ctl.lock;

	// Cause state.
	logic [1:0] soft_interrupt_bits_q;
	logic [4:0] exception_cause_code_q;
	logic       branch_delay_flag_q;
	logic [1:0] cop_err_q;

	wire logic int_any;
	wire logic halt_exit;
	assign int_any   = |{pending_interrupts, soft_interrupt_bits_q};
	assign halt_exit = cache_ctl.halt && int_any;

	// Config register next value; software bits only land when unlocked.
	cache_ctl_t cfg_wval;
	cache_ctl_t cfg_d;
	assign cfg_wval.lock                      = reg_wdata[`CFG_LOCK_BIT];
	assign cfg_wval.block_refill              = reg_wdata[`CFG_BLKREF_BIT];
	assign cfg_wval.dcache_index              = reg_wdata[`CFG_DIDX_LSB +: 2];
	assign cfg_wval.halt                      = reg_wdata[`CFG_HALT_BIT];
	assign cfg_wval.icache_index              = reg_wdata[`CFG_IIDX_LSB +: 2];
	assign cfg_wval.clock_divide_select       = reg_wdata[`CFG_DIV_LSB +: 3];
	assign cfg_wval.force_data_miss           = reg_wdata[`CFG_FDM_BIT];
	assign cfg_wval.force_instr_miss          = reg_wdata[`CFG_FIM_BIT];
	assign cfg_wval.data_cache_write_inhibit  = reg_wdata[`CFG_DWI_BIT];
	assign cfg_wval.instr_cache_write_inhibit = reg_wdata[`CFG_IWI_BIT];

	// A software write in the same cycle as a halt exit wins, so a fresh halt is
	// taken and then released by the still pending interrupt one cycle later.
	always_comb begin
		cfg_d = cache_ctl;
		if (cfg_wr_en) begin
			cfg_d = cfg_wval;
		end else if (halt_exit) begin
			cfg_d.halt                = 1'h0;
			cfg_d.clock_divide_select = `DIV_RST;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cache_ctl.lock                      <= 1'h0;
			cache_ctl.block_refill              <= 1'h0;
			cache_ctl.dcache_index              <= `IDX_RST;
			cache_ctl.halt                      <= 1'h0;
			cache_ctl.icache_index              <= `IDX_RST;
			cache_ctl.clock_divide_select       <= `DIV_RST;
			cache_ctl.force_data_miss           <= 1'h0;
			cache_ctl.force_instr_miss          <= 1'h0;
			cache_ctl.data_cache_write_inhibit  <= 1'h0;
			cache_ctl.instr_cache_write_inhibit <= 1'h0;
		end else begin
			cache_ctl <= cfg_d;
		end
	end

	// Clock divider: a tick every 2**code cycles, every cycle for reserved code 7; both pipeline and bus use it.
	logic [5:0] div_cnt_q;
	wire logic       div_active;
	wire logic [5:0] div_limit;
	wire logic       tick;
	assign div_active = (cache_ctl.clock_divide_select != `DIV_RST) &&
	                    (cache_ctl.clock_divide_select != `DIV_RESERVED);
	assign div_limit  = 6'((7'h01 << cache_ctl.clock_divide_select) - 7'h01);
	assign tick       = !div_active || (div_cnt_q >= div_limit);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt_q <= 6'h00;
		end else begin
			div_cnt_q <= tick ? 6'h00 : div_cnt_q + 6'h01;
		end
	end

	// The divider gives an enable, not a clock, so no gated clock leaves here.
	assign pipe_bus_tick  = tick;
	assign pipeline_stall = cache_ctl.halt || !tick;

	// Cache control outputs.
	assign force_data_miss    = cache_ctl.force_data_miss || emu_force;
	assign force_instr_miss   = cache_ctl.force_instr_miss || emu_force;
	assign data_refill_words  = cache_ctl.block_refill ? `QUAD_WORDS : `SINGLE_WORDS;
	assign instr_refill_words = `QUAD_WORDS;
	// Forced misses never gate writes; only the inhibit bits do.
	assign dcache_wr_en = (dcache_refill_wr || dcache_store_wr) &&
	                      !cache_ctl.data_cache_write_inhibit;
	assign icache_wr_en = icache_refill_wr &&
	                      !cache_ctl.instr_cache_write_inhibit;

	// Exception capture; translation and reserved codes cannot be recorded.
	wire logic code_legal;
	wire logic exc_take;
	assign code_legal = (exc_in.code == 5'h00) ||
	                    ((exc_in.code > `EXC_TLB_LAST) &&
	                     (exc_in.code <= `EXC_LAST_LEGAL));
	assign exc_take   = exc_in.valid && code_legal;
	assign cause_wr   = reg_wr && cause_sel;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			exception_cause_code_q <= 5'h00;
			branch_delay_flag_q    <= 1'h0;
			cop_err_q              <= 2'h0;
			exception_return_pc    <= 32'h0000_0000;
		end else if (exc_take) begin
			exception_cause_code_q <= exc_in.code;
			branch_delay_flag_q    <= exc_in.in_delay;
			exception_return_pc    <= exc_in.in_delay ? exc_in.pc - `PC_STEP
			                                          : exc_in.pc;
			if (exc_in.code == `EXC_CPU) begin
				cop_err_q <= exc_in.cop_unit;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			soft_interrupt_bits_q <= 2'h0;
		end else if (cause_wr) begin
			soft_interrupt_bits_q <= reg_wdata[`CAU_SOFT_LSB +: 2];
		end
	end

	// Read mux; data stand one cycle after the strobe and read zero otherwise.
	wire logic [31:0] cfg_rval;
	wire logic [31:0] cause_rval;
	wire logic [31:0] rd_mux;
	assign cfg_rval   = {cache_ctl.lock, 1'h1, cache_ctl.block_refill,
	                     cache_ctl.dcache_index, 1'h0, cache_ctl.halt,
	                     cache_ctl.icache_index, cache_ctl.clock_divide_select,
	                     cache_ctl.force_data_miss, cache_ctl.force_instr_miss,
	                     cache_ctl.data_cache_write_inhibit,
	                     cache_ctl.instr_cache_write_inhibit, 16'h0000};
	assign cause_rval = {branch_delay_flag_q, 1'h0, cop_err_q, 12'h000,
	                     pending_interrupts, soft_interrupt_bits_q, 1'h0,
	                     exception_cause_code_q, 2'h0};
	assign rd_mux     = cfg_sel ? cfg_rval : (cause_sel ? cause_rval : 32'h0000_0000);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Checks.
	localparam int SYNC_MIN = 1;
	localparam int SYNC_MAX = 3;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_pin_held;
		emulator_miss_force_pin [*4];
	endsequence

	sequence s_fast_tick;
		(cache_ctl.clock_divide_select == 3'h1) && tick && !cfg_wr_en && !halt_exit;
	endsequence

	a_halt_exit_clr: assert property (halt_exit && !cfg_wr_en |=>
		!cache_ctl.halt && cache_ctl.clock_divide_select == 3'h0)
		else $error("halt exit did not clear halt and divide");
	a_halt_stalls: assert property (cache_ctl.halt |-> pipeline_stall)
		else $error("halt did not stall the pipeline");
	a_lock_holds: assert property (cache_ctl.lock && cfg_wr && !halt_exit |=>
		$stable(cache_ctl))
		else $error("locked config changed on write");
	a_emu_force: assert property (s_pin_held |->
		##[SYNC_MIN:SYNC_MAX] (force_data_miss && force_instr_miss))
		else $error("emulator pin did not force misses");
	a_dwr_block: assert property (cache_ctl.data_cache_write_inhibit &&
		(dcache_refill_wr || dcache_store_wr) |-> !dcache_wr_en)
		else $error("data cache written while inhibited");
	a_iwr_block: assert property (cache_ctl.instr_cache_write_inhibit &&
		icache_refill_wr |-> !icache_wr_en)
		else $error("instruction cache written while inhibited");
	a_div2_period: assert property (s_fast_tick |=> !tick ##1 tick)
		else $error("divide by two period wrong");
	a_reserved_full: assert property (cache_ctl.clock_divide_select == 3'h7 |->
		tick)
		else $error("reserved divide code slowed the clock");
	a_cause_code: assert property (exc_take |=>
		exception_cause_code_q == $past(exc_in.code) &&
		branch_delay_flag_q == $past(exc_in.in_delay))
		else $error("exception code or delay flag not captured");
	a_return_pc: assert property (exc_take && exc_in.in_delay |=>
		exception_return_pc == $past(exc_in.pc) - 32'h0000_0004)
		else $error("return address does not point at branch");
	a_no_tlb_code: assert property (!(exception_cause_code_q inside {[5'h01:5'h03]}))
		else $error("translation code reported");
	a_soft_write: assert property (cause_wr |=>
		soft_interrupt_bits_q == $past(reg_wdata[9:8]))
		else $error("software interrupt bits not written");
	a_cop_err: assert property (exc_take && exc_in.code == 5'h0b |=>
		cop_err_q == $past(exc_in.cop_unit))
		else $error("coprocessor number not recorded");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	a_refill_size: assert property (data_refill_words ==
		(cache_ctl.block_refill ? 3'h4 : 3'h1))
		else $error("data refill size wrong");

	// Pin-side checks allow for the synchroniser delay before a level counts.
	sequence s_pin_low;
		(!emulator_miss_force_pin) [*4];
	endsequence

	sequence s_ints_held;
		$stable(hw_int_pins) [*4];
	endsequence

	sequence s_slow_tick;
		(cache_ctl.clock_divide_select == 3'h6) && tick && !cfg_wr_en && !halt_exit;
	endsequence

	a_force_follow: assert property (s_pin_low |->
		##[SYNC_MIN:SYNC_MAX] ((force_data_miss == cache_ctl.force_data_miss) &&
		(force_instr_miss == cache_ctl.force_instr_miss)))
		else $error("force outputs do not follow the register with pin low");
	a_data_force: assert property (cache_ctl.force_data_miss |-> force_data_miss)
		else $error("data force bit did not force misses");
	a_instr_force: assert property (cache_ctl.force_instr_miss |-> force_instr_miss)
		else $error("instruction force bit did not force misses");
	a_pend_show: assert property (s_ints_held |=>
		pending_interrupts == $past(hw_int_pins))
		else $error("pending field does not show interrupt pins");
	a_slow_gap: assert property (s_slow_tick |-> ##64 tick)
		else $error("divide by 64 period wrong");
	// A ratio change may leave the count high for one cycle; the next tick clears it.
	a_div_bound: assert property (div_active &&
		$stable(cache_ctl.clock_divide_select) |-> div_cnt_q <= div_limit)
		else $error("divider count past its limit");
	a_undiv_tick: assert property (cache_ctl.clock_divide_select == 3'h0 |-> tick)
		else $error("undivided setting dropped a tick");
	a_tick_stall: assert property (!tick |-> pipeline_stall)
		else $error("pipeline ran between divided ticks");
	a_stall_free: assert property (!cache_ctl.halt && tick |-> !pipeline_stall)
		else $error("pipeline stalled without cause");
	a_halt_wait: assert property (cache_ctl.halt && !int_any && !cfg_wr_en |=>
		cache_ctl.halt)
		else $error("halt left without an interrupt");
	a_lock_sticky: assert property (cache_ctl.lock |=> cache_ctl.lock)
		else $error("lock bit fell before reset");
	a_cfg_force: assert property (cfg_wr_en |=>
		cache_ctl.force_data_miss == $past(reg_wdata[19]) &&
		cache_ctl.force_instr_miss == $past(reg_wdata[18]))
		else $error("force bits not written");
	a_cfg_inhibit: assert property (cfg_wr_en |=>
		cache_ctl.data_cache_write_inhibit == $past(reg_wdata[17]) &&
		cache_ctl.instr_cache_write_inhibit == $past(reg_wdata[16]))
		else $error("write inhibit bits not written");
	a_cfg_divide: assert property (cfg_wr_en |=>
		cache_ctl.clock_divide_select == $past(reg_wdata[22:20]))
		else $error("divide field not written");
	a_cfg_read: assert property (reg_rd && cfg_sel |=>
		reg_rdata[30] && (reg_rdata[31] == $past(cache_ctl.lock)))
		else $error("config read data wrong");
	a_dwr_pass: assert property ((dcache_refill_wr || dcache_store_wr) &&
		!cache_ctl.data_cache_write_inhibit |-> dcache_wr_en)
		else $error("data cache write lost");
	a_iwr_pass: assert property (icache_refill_wr &&
		!cache_ctl.instr_cache_write_inhibit |-> icache_wr_en)
		else $error("instruction refill write lost");
	a_dwr_idle: assert property (!dcache_refill_wr && !dcache_store_wr |-> !dcache_wr_en)
		else $error("data cache written without request");
	a_iwr_idle: assert property (!icache_refill_wr |-> !icache_wr_en)
		else $error("instruction cache written without request");
	a_ifill_size: assert property (instr_refill_words == 3'h4)
		else $error("instruction refill size wrong");
	a_code_legal: assert property ((exception_cause_code_q == 5'h00) ||
		(exception_cause_code_q inside {[5'h04:5'h0c]}))
		else $error("reserved exception code reported");
	a_code_hold: assert property (!exc_take |=>
		$stable(exception_cause_code_q) && $stable(branch_delay_flag_q))
		else $error("read-only cause field changed");
	a_cop_hold: assert property (!(exc_take && exc_in.code == 5'h0b) |=>
		$stable(cop_err_q))
		else $error("coprocessor field changed without cause");
	a_exc_drop: assert property (exc_in.valid && !code_legal |=>
		$stable(exception_cause_code_q) && $stable(exception_return_pc))
		else $error("illegal exception code was taken");
	a_pc_plain: assert property (exc_take && !exc_in.in_delay |=>
		exception_return_pc == $past(exc_in.pc))
		else $error("return address wrong outside delay slot");
	a_pc_hold: assert property (!exc_take |=> $stable(exception_return_pc))
		else $error("return address changed without exception");
	a_soft_hold: assert property (!cause_wr |=> $stable(soft_interrupt_bits_q))
		else $error("software interrupt bits changed without write");
	a_cause_read: assert property (reg_rd && cause_sel |=>
		reg_rdata[9:8] == $past(soft_interrupt_bits_q) &&
		reg_rdata[6:2] == $past(exception_cause_code_q))
		else $error("cause read data wrong");

endmodule
`default_nettype wire

// [sim/tb_cache_config_and_cause_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_cache_config_and_cause_regs
	import cache_cause_pkg::*;
();
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	exc_event_t  exc_in = '0;
	logic [5:0]  hw_int_pins = 6'h00;
	logic        emu_pin = 1'b0;
	logic        d_ref = 1'b0;
	logic        d_st = 1'b0;
	logic        i_ref = 1'b0;
	logic        dcache_wr_en;
	logic        icache_wr_en;
	logic        force_data_miss;
	logic        force_instr_miss;
	logic [2:0]  data_refill_words;
	logic [2:0]  instr_refill_words;
	logic        pipe_bus_tick;
	logic        pipeline_stall;
	cache_ctl_t  cache_ctl;
	logic [31:0] exception_return_pc;
	int          failures = 0;
	int          checked = 0;
	logic [31:0] v;
	int          c;

	always #12.5 ref_clk = ~ref_clk;

	cache_config_and_cause_regs #(.HW_INTS(6)) DUT (
		.ref_clk                 (ref_clk),
		.rst                     (rst),
		.reg_addr                (reg_addr),
		.reg_wdata               (reg_wdata),
		.reg_wr                  (reg_wr),
		.reg_rd                  (reg_rd),
		.reg_rdata               (reg_rdata),
		.exc_in                  (exc_in),
		.hw_int_pins             (hw_int_pins),
		.emulator_miss_force_pin (emu_pin),
		.dcache_refill_wr        (d_ref),
		.dcache_store_wr         (d_st),
		.icache_refill_wr        (i_ref),
		.dcache_wr_en            (dcache_wr_en),
		.icache_wr_en            (icache_wr_en),
		.force_data_miss         (force_data_miss),
		.force_instr_miss        (force_instr_miss),
		.data_refill_words       (data_refill_words),
		.instr_refill_words      (instr_refill_words),
		.pipe_bus_tick           (pipe_bus_tick),
		.pipeline_stall          (pipeline_stall),
		.cache_ctl               (cache_ctl),
		.exception_return_pc     (exception_return_pc)
	);

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic exc(input logic [4:0] k, input logic dl, input logic [1:0] u, input logic [31:0] p);
		@(posedge ref_clk);
		exc_in <= '{valid: 1'b1, code: k, in_delay: dl, cop_unit: u, pc: p};
		@(posedge ref_clk);
		exc_in.valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic ticks(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1 if (pipe_bus_tick === 1'b1) k++;
		end
	endtask

	// The cache outputs are sampled a little after the edge, where they settle.
	task automatic cache_io(input logic [31:0] cfg, input logic [4:0] e, input logic r);
		wr(5'h03, cfg);
		repeat (6) @(posedge ref_clk);
		d_st <= !r;
		d_ref <= r;
		i_ref <= 1'b1;
		#1 chk("cache outs", {27'h0, e}, {27'h0, force_data_miss, force_instr_miss,
			dcache_wr_en, icache_wr_en, data_refill_words == 3'h4});
		@(posedge ref_clk);
		d_st <= 1'b0;
		d_ref <= 1'b0;
		i_ref <= 1'b0;
	endtask

	task automatic t_reset;
		rd(5'h03, v);
		chk("cfg reset", 32'h4000_0000, v);
		rd(5'h0d, v);
		chk("cause reset", 32'h0, v);
		rd(5'h07, v);
		chk("unmapped", 32'h0, v);
		chk("words", 32'h0000_0014, {24'h0, 1'b0, data_refill_words, 1'b0, instr_refill_words});
		$display("test reset done");
	endtask

	task automatic t_cache;
		cache_io(32'h200c_0000, 5'h1f, 1'b1);
		cache_io(32'h0003_0000, 5'h00, 1'b0);
		emu_pin <= 1'b1;
		cache_io(32'h0002_0000, 5'h1a, 1'b1);
		emu_pin <= 1'b0;
		$display("test cache done");
	endtask

	task automatic t_div;
		wr(5'h03, 32'h0010_0000);
		repeat (70) @(posedge ref_clk);
		ticks(64, c);
		chk("div2 ticks", 32'd32, 32'(c));
		wr(5'h03, 32'h0000_0000);
		wr(5'h03, 32'h0060_0000);
		repeat (70) @(posedge ref_clk);
		ticks(128, c);
		chk("div64 ticks", 32'd2, 32'(c));
		wr(5'h03, 32'h0000_0000);
		wr(5'h03, 32'h0070_0000);
		repeat (70) @(posedge ref_clk);
		ticks(32, c);
		chk("reserved ticks", 32'd32, 32'(c));
		$display("test divider done");
	endtask

	task automatic t_halt;
		wr(5'h03, 32'h0210_0000);
		ticks(16, c);
		chk("stall held", 32'h1, {31'h0, pipeline_stall});
		wr(5'h0d, 32'h0000_0100);
		repeat (2) @(posedge ref_clk);
		#1 chk("halt exit", 32'h0, {28'h0, cache_ctl.halt, cache_ctl.clock_divide_select});
		chk("stall off", 32'h0, {31'h0, pipeline_stall});
		wr(5'h0d, 32'h0000_0000);
		$display("test halt done");
	endtask

	task automatic t_cause;
		exc(5'h0b, 1'b1, 2'h2, 32'h0000_1008);
		rd(5'h0d, v);
		chk("cause cpu", 32'ha000_002c, v);
		chk("return pc", 32'h0000_1004, exception_return_pc);
		exc(5'h02, 1'b0, 2'h1, 32'h0000_2000);
		rd(5'h0d, v);
		chk("cause tlb", 32'ha000_002c, v);
		exc(5'h0c, 1'b0, 2'h1, 32'h0000_3000);
		rd(5'h0d, v);
		chk("cause ovf", 32'h2000_0030, v);
		chk("return pc2", 32'h0000_3000, exception_return_pc);
		exc(5'h0d, 1'b1, 2'h3, 32'h0000_4000);
		rd(5'h0d, v);
		chk("cause rsvd", 32'h2000_0030, v);
		wr(5'h0d, 32'hffff_ffff);
		rd(5'h0d, v);
		chk("soft set", 32'h2000_0330, v);
		wr(5'h0d, 32'h0000_0000);
		hw_int_pins <= 6'h2a;
		repeat (5) @(posedge ref_clk);
		rd(5'h0d, v);
		chk("pending", 32'h2000_a830, v);
		hw_int_pins <= 6'h00;
		exc(5'h00, 1'b0, 2'h3, 32'h0000_0040);
		rd(5'h0d, v);
		chk("cause int", 32'h2000_0000, v);
		chk("return pc3", 32'h0000_0040, exception_return_pc);
		$display("test cause done");
	endtask

	task automatic t_lock;
		wr(5'h03, 32'ha000_0000);
		wr(5'h03, 32'h000f_0000);
		rd(5'h03, v);
		chk("locked cfg", 32'he000_0000, v);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(5'h03, v);
		chk("cfg after reset", 32'h4000_0000, v);
		wr(5'h03, 32'h4008_0000);
		rd(5'h03, v);
		chk("unlocked cfg", 32'h4008_0000, v);
		$display("test lock done");
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Whole run is well under two thousand cycles; the limit leaves ample slack.
	initial begin
		#(25 * 5000);
		failures++;
		end_sim();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_cache();
		t_div();
		t_halt();
		t_cause();
		t_lock();
		end_sim();
	end
endmodule
`default_nettype wire
